// file: bench/spcg_sleep_periph_clock_gating_asserts.sv
// Checker bound to the clock gating block top ports.
// Assumes one pclk domain and presetn asynchronous, active low.
`default_nettype none
module spcg_chk
    import spcg_pkg::*;
#(
    parameter int UNITS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SPCG_ADDR_W-1:0] paddr,
    input wire logic [SPCG_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [SPCG_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic [UNITS-1:0] unit_access_sel,
    input wire logic unit_access_fault,
    input wire logic [UNITS-1:0] unit_clk_en,
    input wire logic [UNITS-1:0] unit_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic gate_ofs;
    logic known_ofs;
    logic wr_acc;
    assign gate_ofs = paddr inside {SPCG_RUN_GATES_OFS, SPCG_SLEEP_GATES_OFS, SPCG_DEEP_GATES_OFS};
    assign known_ofs = gate_ofs || paddr inside {SPCG_RUN_CONFIG_OFS, SPCG_ACTIVE_GATES_OFS,
        SPCG_MODE_STATUS_OFS};
    assign wr_acc = psel && penable && pwrite;
    sequence s_read;
        psel && penable && !pwrite;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
        unit_access_fault == |(unit_access_sel & ~unit_clk_en)) else $error("fault flag wrong");
    AST_CLK_GATED: assert property (@(negedge pclk) disable iff (!presetn)
        unit_clk == $past(unit_clk_en)) else $error("unit clock not following enable");
    AST_RESET_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> unit_clk_en == '0) else $error("unit clocked after reset");
    AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        s_read ##0 gate_ofs |-> (prdata & ~SPCG_GATE_MASK) == '0) else $error("reserved bit set");
    AST_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && gate_ofs |-> !pslverr) else $error("gating register refused");
    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !known_ofs |-> pslverr && prdata == '0) else $error("bad address taken");
    AST_EN_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(unit_clk_en) |-> $past(wr_acc, 2) || $past(sleep_req, 2) != $past(sleep_req, 3)
        || $past(deep_sleep_req, 2) != $past(deep_sleep_req, 3)) else $error("enable moved alone");
    AST_MODE_RD: assert property (@(posedge pclk) disable iff (!presetn)
        s_read ##0 paddr == SPCG_MODE_STATUS_OFS |-> prdata == {30'h0, $past(deep_sleep_req, 2)
        ? 2'h2 : {1'b0, $past(sleep_req, 2)}}) else $error("mode status wrong");
endmodule // spcg_chk

bind spcg_sleep_periph_clock_gating spcg_chk #(.UNITS(UNITS)) spcg_chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_req,
    .deep_sleep_req, .unit_access_sel, .unit_access_fault, .unit_clk_en, .unit_clk);
`default_nettype wire

// file: bench/spcg_sleep_periph_clock_gating_tb.sv
// Self-checking bench with a register and gating model.
// Assumes the unit bank model and the bound checker.
`default_nettype none
module spcg_sleep_periph_clock_gating_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spcg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, sleep_req, deep_sleep_req, m_auto;
    logic pready, pslverr, unit_access_fault;
    logic [SPCG_ADDR_W-1:0] paddr;
    logic [SPCG_DATA_W-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] m_mode;
    logic [7:0] want_sel, unit_access_sel, unit_clk_en, unit_clk;
    logic [15:0] pulse_cnt [8];
    logic [31:0] m_reg [3];
    logic [11:0] ofs [6];
    int err_total = 0;
    int n_checks = 0;
    integer seed = 32'hD4132121;
    spcg_sleep_periph_clock_gating spcg_sleep_periph_clock_gating_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_req,
        .deep_sleep_req, .unit_access_sel, .unit_access_fault, .unit_clk_en, .unit_clk);
    spcg_unit_bank spcg_unit_bank_i (.pclk, .presetn, .unit_clk, .want_sel, .unit_access_sel,
        .pulse_cnt);
    // ------------------------------------------------------------
    // Model, bus and checks
    // ------------------------------------------------------------
    function automatic logic [31:0] sel_reg();
        return m_auto ? m_reg[m_mode] : m_reg[0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        logic [31:0] ex;
        int ix;
        int k;
        ix = -1;
        for (int i = 0; i < 6; i++) begin
            if (ofs[i] === a) ix = i;
        end
        ex = ix < 0 ? 32'h0 : ix < 3 ? m_reg[ix] : ix == 3 ? {31'h0, m_auto}
            : ix == 4 ? sel_reg() : {30'h0, m_mode};
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
        chk({31'h0, pslverr}, {31'h0, ix < 0 || (w && ix > 3)});
        if (!w) chk(prdata, ex);
        {psel, penable} <= 2'b00;
        if (w && ix >= 0 && ix < 3) begin
            for (int b = 0; b < 4; b++) begin
                if (s[b]) m_reg[ix][8*b +: 8] = d[8*b +: 8];
            end
            m_reg[ix] &= SPCG_GATE_MASK;
        end
        if (w && ix == 3 && s[0]) m_auto = d[0];
    endtask
    task automatic chk_units();
        logic [15:0] c0 [8];
        logic [31:0] r;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        r = sel_reg();
        c0 = pulse_cnt;
        repeat (10) @(negedge pclk);
        for (int u = 0; u < 8; u++) begin
            chk({31'h0, unit_clk_en[u]}, {31'h0, r[SPCG_UNIT_BIT[u]]});
            chk({16'h0, 16'(pulse_cnt[u] - c0[u])}, r[SPCG_UNIT_BIT[u]] ? 32'hA : 32'h0);
        end
        for (int u = 0; u < 8; u++) begin
            @(posedge pclk);
            want_sel <= 8'(1 << u);
            repeat (2) @(negedge pclk);
            chk({31'h0, unit_access_fault}, {31'h0, !r[SPCG_UNIT_BIT[u]]});
        end
        @(posedge pclk);
        want_sel <= '0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done();
    end
    initial begin
        logic [31:0] d;
        logic [3:0] s;
        {presetn, psel, penable, pwrite, sleep_req, deep_sleep_req, m_auto, m_mode} = '0;
        {paddr, pwdata, pstrb, want_sel} = '0;
        m_reg = '{default: '0};
        ofs = '{SPCG_RUN_GATES_OFS, SPCG_SLEEP_GATES_OFS, SPCG_DEEP_GATES_OFS,
            SPCG_RUN_CONFIG_OFS, SPCG_ACTIVE_GATES_OFS, SPCG_MODE_STATUS_OFS};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ofs[i], 32'h0, 4'hF);
        end
        chk_units();
        for (int i = 0; i < 12; i++) begin
            acc(1'b0, ofs[i % 3], 32'h0, 4'hF);
            d = $random(seed);
            s = (i < 6) ? 4'($random(seed)) : 4'hF;
            if (i >= 6) d = m_reg[i % 3] ^ (d & SPCG_GATE_MASK);
            acc(1'b1, ofs[i % 3], d, s);
            chk_units();
        end
        acc(1'b1, 12'h0F0, 32'hFFFFFFFF, 4'hF);
        acc(1'b1, SPCG_ACTIVE_GATES_OFS, 32'hFFFFFFFF, 4'hF);
        acc(1'b1, SPCG_MODE_STATUS_OFS, 32'hFFFFFFFF, 4'hF);
        acc(1'b0, 12'h110, 32'h0, 4'hF);
        for (int au = 0; au < 2; au++) begin
            acc(1'b1, SPCG_RUN_CONFIG_OFS, 32'(au), 4'hF);
            for (int m = 0; m < 3; m++) begin
                @(posedge pclk);
                sleep_req <= (m != 0);
                deep_sleep_req <= (m == 2);
                m_mode = 2'(m);
                acc(1'b1, ofs[m], $random(seed), 4'hF);
                chk_units();
                acc(1'b0, SPCG_MODE_STATUS_OFS, 32'h0, 4'hF);
                acc(1'b0, SPCG_ACTIVE_GATES_OFS, 32'h0, 4'hF);
            end
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_reg = '{default: '0};
        m_auto = 1'b0;
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, ofs[i], 32'h0, 4'hF);
        end
        chk_units();
        test_done();
    end
endmodule // spcg_sleep_periph_clock_gating_tb
`default_nettype wire

// file: bench/spcg_unit_bank.sv
// Gated units and their bus decoder, facing the clock gating block.
// Assumes unit clocks come from the block; the decoder runs on pclk.
`default_nettype none
module spcg_unit_bank #(
    parameter int UNITS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [UNITS-1:0] unit_clk,
    input wire logic [UNITS-1:0] want_sel,
    output logic [UNITS-1:0] unit_access_sel,
    output logic [15:0] pulse_cnt [UNITS]
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Decoder and per-unit edge counters
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            unit_access_sel <= '0;
        else
            unit_access_sel <= want_sel;
    end
    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        always_ff @(posedge unit_clk[u] or negedge presetn) begin
            if (!presetn)
                pulse_cnt[u] <= '0;
            else
                pulse_cnt[u] <= pulse_cnt[u] + 16'h1;
        end
    end
endmodule // spcg_unit_bank
`default_nettype wire

// file: hw/spcg_clock_gate.sv
// Glitch-free clock gate cell for one peripheral clock.
// Assumes the enable is stable around the rising edge of clk_in.
`default_nettype none

module spcg_clock_gate (
    input wire logic clk_in,
    input wire logic enable,
    output logic clk_out
);
    import spcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic enable_held;

    // ----------------------------------------------------------------
    // Enable latch, open only while the clock is low
    // ----------------------------------------------------------------
    always_latch begin
        if (!clk_in) begin
            enable_held = enable;
        end
    end

    // ----------------------------------------------------------------
    // Gated clock
    // ----------------------------------------------------------------
    assign clk_out = clk_in & enable_held;

endmodule // spcg_clock_gate

`default_nettype wire

// file: hw/spcg_pkg.sv
// Constants for the sleep peripheral clock gating block.
// Assumes a 32-bit APB slave on pclk with byte addresses.
`default_nettype none

package spcg_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int SPCG_ADDR_W = 12;
    localparam int SPCG_DATA_W = 32;
    localparam int SPCG_UNITS = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [SPCG_ADDR_W-1:0] SPCG_RUN_GATES_OFS = 12'h104;
    localparam logic [SPCG_ADDR_W-1:0] SPCG_SLEEP_GATES_OFS = 12'h114;
    localparam logic [SPCG_ADDR_W-1:0] SPCG_DEEP_GATES_OFS = 12'h124;
    localparam logic [SPCG_ADDR_W-1:0] SPCG_RUN_CONFIG_OFS = 12'h200;
    localparam logic [SPCG_ADDR_W-1:0] SPCG_ACTIVE_GATES_OFS = 12'h204;
    localparam logic [SPCG_ADDR_W-1:0] SPCG_MODE_STATUS_OFS = 12'h208;

    // ----------------------------------------------------------------
    // Field layout of the gating registers
    // ----------------------------------------------------------------
    localparam int SPCG_ASYNC_SERIAL0_BIT = 0;
    localparam int SPCG_SYNC_SERIAL0_BIT = 4;
    localparam int SPCG_SYNC_SERIAL1_BIT = 5;
    localparam int SPCG_TWOWIRE_PORT0_BIT = 12;
    localparam int SPCG_GP_COUNTER0_BIT = 16;
    localparam int SPCG_GP_COUNTER1_BIT = 17;
    localparam int SPCG_GP_COUNTER2_BIT = 18;
    localparam int SPCG_GP_COUNTER3_BIT = 19;

    // Unit index to register bit position
    localparam int SPCG_UNIT_BIT [SPCG_UNITS] = '{
        SPCG_ASYNC_SERIAL0_BIT, SPCG_SYNC_SERIAL0_BIT, SPCG_SYNC_SERIAL1_BIT,
        SPCG_TWOWIRE_PORT0_BIT, SPCG_GP_COUNTER0_BIT, SPCG_GP_COUNTER1_BIT,
        SPCG_GP_COUNTER2_BIT, SPCG_GP_COUNTER3_BIT};

    // Writable bits; all others read zero
    localparam logic [SPCG_DATA_W-1:0] SPCG_GATE_MASK = 32'h000F1031;
    localparam logic [SPCG_DATA_W-1:0] SPCG_GATE_RESET = 32'h00000000;

    // ----------------------------------------------------------------
    // Run-mode clock configuration
    // ----------------------------------------------------------------
    localparam int SPCG_AUTO_GATING_BIT = 0;
    localparam logic SPCG_AUTO_GATING_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Power modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SPCG_MODE_RUN,
        SPCG_MODE_SLEEP,
        SPCG_MODE_DEEP_SLEEP
    } spcg_mode_t;

    localparam int SPCG_MODE_LSB = 0;
    localparam int SPCG_MODE_MSB = 1;

endpackage : spcg_pkg

`default_nettype wire

// file: hw/spcg_sleep_periph_clock_gating.sv
// Peripheral clock gating control for run, sleep and deep-sleep modes.
// Assumes an APB master on pclk and mode requests from logic on pclk.
//
// Notes on behaviour
// - A unit's clock runs only while its selected gate bit is one.
// - An access to a unit whose clock is gated off gets a bus fault.
// - Sleep and deep-sleep gating registers reset to all zeros.
// - Run register in run, sleep register in sleep, deep register in deep sleep.
// - Sleep and deep-sleep registers govern clocks only with auto gating set.
// - General-purpose counter gates three..zero sit at bits 19..16, read-write.
// - Two-wire port zero gate sits at bit 12, read-write.
// - Synchronous serial gates one and zero sit at bits 5 and 4.
// - Asynchronous serial zero gate sits at bit 0, read-write.
// - Reserved bits 31:20, 15:13, 11:6, 3:1 are read-only zero.
// - Sleep register at offset 0x114, deep-sleep register at 0x124.
// - Run gating register at offset 0x104, same layout, resets to zero.
//
// Implementation choice: the APB register port.
`default_nettype none

module spcg_sleep_periph_clock_gating #(
    parameter int UNITS = spcg_pkg::SPCG_UNITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spcg_pkg::SPCG_ADDR_W-1:0] paddr,
    input wire logic [spcg_pkg::SPCG_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [spcg_pkg::SPCG_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic [UNITS-1:0] unit_access_sel,
    output logic unit_access_fault,
    output logic [UNITS-1:0] unit_clk_en,
    output logic [UNITS-1:0] unit_clk
);
    import spcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [SPCG_DATA_W-1:0] run_unit_clock_gates;
    logic [SPCG_DATA_W-1:0] sleep_unit_clock_gates;
    logic [SPCG_DATA_W-1:0] deep_sleep_unit_clock_gates;
    logic auto_gating_select;
    spcg_mode_t power_mode;
    spcg_mode_t next_power_mode;
    logic [SPCG_DATA_W-1:0] selected_gates;
    logic [SPCG_DATA_W-1:0] active_gates;
    logic [UNITS-1:0] next_unit_clk_en;
    logic access_phase;
    logic wr_access;
    logic rd_access;
    logic hit_run;
    logic hit_sleep;
    logic hit_deep;
    logic hit_config;
    logic hit_active;
    logic hit_mode;
    logic hit_any;
    logic hit_read_only;
    logic [SPCG_DATA_W-1:0] strobe_mask;
    logic [SPCG_DATA_W-1:0] next_prdata;

    // ----------------------------------------------------------------
    // APB access qualification
    // ----------------------------------------------------------------
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite;
    assign rd_access = access_phase & ~pwrite;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign hit_run = (paddr == SPCG_RUN_GATES_OFS);
    assign hit_sleep = (paddr == SPCG_SLEEP_GATES_OFS);
    assign hit_deep = (paddr == SPCG_DEEP_GATES_OFS);
    assign hit_config = (paddr == SPCG_RUN_CONFIG_OFS);
    assign hit_active = (paddr == SPCG_ACTIVE_GATES_OFS);
    assign hit_mode = (paddr == SPCG_MODE_STATUS_OFS);
    assign hit_read_only = hit_active | hit_mode;
    assign hit_any = hit_run | hit_sleep | hit_deep | hit_config | hit_read_only;

    // ----------------------------------------------------------------
    // Byte strobes widened to a bit mask
    // ----------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            strobe_mask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // ----------------------------------------------------------------
    // Handshake and error response
    // ----------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // Unmapped addresses and writes to status registers are refused
    assign pslverr = access_phase & (~hit_any | (pwrite & hit_read_only));

    // ----------------------------------------------------------------
    // Run gating register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_unit_clock_gates <= SPCG_GATE_RESET;
        end else if (wr_access && hit_run) begin
            run_unit_clock_gates <= (run_unit_clock_gates & ~strobe_mask)
                | (pwdata & strobe_mask & SPCG_GATE_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Sleep gating register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_unit_clock_gates <= SPCG_GATE_RESET;
        end else if (wr_access && hit_sleep) begin
            sleep_unit_clock_gates <= (sleep_unit_clock_gates & ~strobe_mask)
                | (pwdata & strobe_mask & SPCG_GATE_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Deep-sleep gating register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_unit_clock_gates <= SPCG_GATE_RESET;
        end else if (wr_access && hit_deep) begin
            deep_sleep_unit_clock_gates <= (deep_sleep_unit_clock_gates & ~strobe_mask)
                | (pwdata & strobe_mask & SPCG_GATE_MASK);
        end
    end

    // ----------------------------------------------------------------
    // Run-mode clock configuration, auto gating bit
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gating_select <= SPCG_AUTO_GATING_RESET;
        end else if (wr_access && hit_config && pstrb[SPCG_AUTO_GATING_BIT / 8]) begin
            auto_gating_select <= pwdata[SPCG_AUTO_GATING_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Power mode tracking
    // ----------------------------------------------------------------
    always_comb begin
        // Deep sleep outranks sleep when both are requested
        if (deep_sleep_req) begin
            next_power_mode = SPCG_MODE_DEEP_SLEEP;
        end else if (sleep_req) begin
            next_power_mode = SPCG_MODE_SLEEP;
        end else begin
            next_power_mode = SPCG_MODE_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_mode <= SPCG_MODE_RUN;
        end else begin
            power_mode <= next_power_mode;
        end
    end

    // ----------------------------------------------------------------
    // Gating register selection
    // ----------------------------------------------------------------
    always_comb begin
        if (!auto_gating_select) begin
            selected_gates = run_unit_clock_gates;
        end else begin
            case (power_mode)
                SPCG_MODE_RUN: begin
                    selected_gates = run_unit_clock_gates;
                end
                SPCG_MODE_SLEEP: begin
                    selected_gates = sleep_unit_clock_gates;
                end
                SPCG_MODE_DEEP_SLEEP: begin
                    selected_gates = deep_sleep_unit_clock_gates;
                end
                default: begin
                    selected_gates = run_unit_clock_gates;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Per-unit enables and gated clocks
    // ----------------------------------------------------------------
    generate
        for (genvar u = 0; u < UNITS; u++) begin : g_unit
            // Bits 0, 4, 5, 12 and 16..19 feed the units
            assign next_unit_clk_en[u] = selected_gates[SPCG_UNIT_BIT[u]];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    unit_clk_en[u] <= 1'b0;
                end else begin
                    unit_clk_en[u] <= next_unit_clk_en[u];
                end
            end

            // Enable settles after the rising edge, cell passes it while low
            spcg_clock_gate u_gate (
                .clk_in(pclk),
                .enable(unit_clk_en[u]),
                .clk_out(unit_clk[u])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Active gates in register layout
    // ----------------------------------------------------------------
    always_comb begin
        active_gates = '0;
        for (int u = 0; u < UNITS; u++) begin
            active_gates[SPCG_UNIT_BIT[u]] = unit_clk_en[u];
        end
    end

    // ----------------------------------------------------------------
    // Bus fault for accesses to unclocked units
    // ----------------------------------------------------------------
    assign unit_access_fault = |(unit_access_sel & ~unit_clk_en);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        next_prdata = '0;
        if (hit_run) begin
            next_prdata = run_unit_clock_gates & SPCG_GATE_MASK;
        end else if (hit_sleep) begin
            next_prdata = sleep_unit_clock_gates & SPCG_GATE_MASK;
        end else if (hit_deep) begin
            next_prdata = deep_sleep_unit_clock_gates & SPCG_GATE_MASK;
        end else if (hit_config) begin
            next_prdata[SPCG_AUTO_GATING_BIT] = auto_gating_select;
        end else if (hit_active) begin
            next_prdata = active_gates;
        end else if (hit_mode) begin
            next_prdata[SPCG_MODE_MSB:SPCG_MODE_LSB] = power_mode;
        end
    end

    // Read data registered in the setup cycle, valid during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end else if (rd_access) begin
            prdata <= prdata;
        end else begin
            prdata <= '0;
        end
    end

endmodule // spcg_sleep_periph_clock_gating

`default_nettype wire
